//--- inc/wsu_defs.vh
// register map, fields, function codes and timing for the shift unit
`ifndef WSU_DEFS_VH
`define WSU_DEFS_VH
// byte offsets on the register bus
`define WSU_CTRL 8'h00
`define WSU_UFLD 8'h04
`define WSU_XVAL 8'h08
`define WSU_OPW 8'h0C
`define WSU_OPEND 8'h2C
`define WSU_RES 8'h2C
`define WSU_CNT 8'h3C
`define WSU_STAT 8'h40
`define WSU_EFFU 8'h44
// control word fields
`define WSU_C_START 31
`define WSU_C_IDX 8
`define WSU_C_AHI 7
`define WSU_C_ALO 4
`define WSU_C_FHI 3
`define WSU_C_FLO 0
// status word fields
`define WSU_S_BUSY 0
`define WSU_S_DONE 1
`define WSU_S_BADF 2
`define WSU_S_RNG 3
// function codes, low part after the 73 major code
`define WSU_F_SRR 4'h0
`define WSU_F_DRR 4'h1
`define WSU_F_SLR 4'h2
`define WSU_F_DLR 4'h3
`define WSU_F_SSR 4'h4
`define WSU_F_DSR 4'h5
`define WSU_F_LSC 4'h6
`define WSU_F_DLSC 4'h7
`define WSU_F_SRL 4'h8
`define WSU_F_DRL 4'h9
`define WSU_F_SLL 4'hA
`define WSU_F_DLL 4'hB
// control register address of accumulator zero
`define WSU_ACC_BASE 7'h0C
// bus answers
`define WSU_OKAY 2'h0
`define WSU_SLVERR 2'h2
// execution times in ns and the clock period
`define WSU_CLK_NS 50
`define WSU_T_SGL_NS 750
`define WSU_T_DBL_NS 875
`define WSU_T_LSC_NS 1125
`define WSU_T_DLSC_NS 2125
`define WSU_CYC(t) (((t) + `WSU_CLK_NS - 1) / `WSU_CLK_NS)
`endif

//--- rtl/wsu_shift_unit.v
// shift unit of the arithmetic section with an axi4-lite register port
`timescale 1ns/1ps
// Function
// - double shifts use 72 bits, single 36
// - right circular: right-end bits re-enter left
// - left circular: left-end bits re-enter right
// - right logical drops bits, zero fills left
// - left logical drops bits, zero fills right
// - algebraic shift only right, sign filled
// - single circular count n same as n-36
// - count is effective address bits six..zero
// - counts above 72 give any result
// - indexing forms address as for others
// - scaling rotates left until top bits differ
// - uniform operand reports 35 or 71
// - scaling loads memory, count to next register
// - all zeros plus zero, all ones minus
// - single rotate right, 0.75 us
// - double rotate right, 0.875 us
// - single logical right, big counts give zero
// - double logical right with zero fill
// - single signfill right copies bit 35
// - pair of register 17 octal is 034
`include "wsu_defs.vh"
module wsu_shift_unit (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // one-hot sequencer states
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;
  // busy time per class, rounded up to whole cycles
  localparam integer CY_SGL = `WSU_CYC(`WSU_T_SGL_NS);
  localparam integer CY_DBL = `WSU_CYC(`WSU_T_DBL_NS);
  localparam integer CY_LSC = `WSU_CYC(`WSU_T_LSC_NS);
  localparam integer CY_DLSC = `WSU_CYC(`WSU_T_DLSC_NS);

  // merge a write word under its byte strobes
  function [31:0] wsu_mrg;
    input [31:0] o;
    input [31:0] n;
    input [3:0] s;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1) begin
        wsu_mrg[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
      end
    end
  endfunction

  // write side holding registers
  reg aw_have_r; // address taken, waiting for data
  reg w_have_r; // data taken, waiting for address
  reg [7:0] wa_r; // held write address
  reg [31:0] wd_r; // held write data
  reg [3:0] ws_r; // held strobes
  // software visible control
  reg [17:0] ufld_r; // instruction u field
  reg [17:0] xval_r; // index register value
  reg [3:0] func_r; // last function written
  reg [3:0] afld_r; // accumulator field
  reg idx_r; // index applied
  // sequencer and results
  reg [1:0] state_r;
  reg [5:0] tmr_r; // cycles left in the run
  reg [3:0] fq_r; // function being run
  reg [3:0] aq_r; // accumulator field being run
  reg [6:0] nq_r; // shift count being run
  reg [17:0] effu_r; // effective u of the last start
  reg [35:0] res0_r; // result for register a
  reg [35:0] res1_r; // result for register a+1
  reg [6:0] rcnt_r; // scaling count
  reg done_r;
  reg badf_r; // last start carried an unknown code
  reg rng_r; // last start had high address bits set
  reg [6:0] dst0_r; // control address of first result
  reg [6:0] dst1_r; // control address of second result
  reg [6:0] dstc_r; // control address of the count

  // a write goes ahead once both halves are held
  wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [7:0] wa = {wa_r[7:2], 2'b00};
  wire wr_ctrl = wr_go & (wa == `WSU_CTRL);
  wire wr_stat = wr_go & (wa == `WSU_STAT);
  wire [31:0] m_ctrl = wsu_mrg({23'h0, idx_r, afld_r, func_r}, wd_r, ws_r);
  wire [31:0] m_u = wsu_mrg({14'h0, ufld_r}, wd_r, ws_r);
  wire [31:0] m_x = wsu_mrg({14'h0, xval_r}, wd_r, ws_r);
  wire idle = state_r[0];

  // effective u: ones-complement index add, end-around carry
  wire [17:0] xadd = m_ctrl[`WSU_C_IDX] ? xval_r : 18'h0;
  wire [18:0] usum = {1'b0, ufld_r} + {1'b0, xadd};
  wire [17:0] effu = usum[17:0] + {17'h0, usum[18]};
  wire [3:0] sfunc = m_ctrl[`WSU_C_FHI:`WSU_C_FLO];
  wire f_ok = (sfunc <= `WSU_F_DLL);
  // a start needs the start bit and an idle unit; an unknown code is flagged and not run
  wire start = wr_ctrl & m_ctrl[`WSU_C_START] & idle;

  // operand words: a, a+1, memory u, memory u+1
  wire [35:0] opnd [0:3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_op
      localparam [7:0] LO = `WSU_OPW + 8 * g;
      localparam [7:0] HI = `WSU_OPW + 8 * g + 4;
      reg [35:0] word_r;
      wire [31:0] ml = wsu_mrg(word_r[31:0], wd_r, ws_r);
      // writes while busy are dropped so a run sees stable inputs
      always @(posedge aclk) begin
        if (!aresetn) begin
          word_r <= 36'h0;
        end else if (wr_go & idle) begin
          if (wa == LO) begin
            word_r[31:0] <= ml;
          end else if ((wa == HI) & ws_r[0]) begin
            word_r[35:32] <= wd_r[3:0];
          end
        end
      end
      assign opnd[g] = word_r;
    end
  endgenerate

  // write channels: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WSU_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wa_r <= 8'h0;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
    end else begin
      if (s_axi_awready & s_axi_awvalid) begin
        wa_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready & s_axi_wvalid) begin
        wd_r <= s_axi_wdata;
        ws_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        // addresses past the map answer slave error
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa > `WSU_EFFU) ? `WSU_SLVERR : `WSU_OKAY;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        // ready again only after the answer, one write at a time
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control registers written by software
  always @(posedge aclk) begin
    if (!aresetn) begin
      ufld_r <= 18'h0;
      xval_r <= 18'h0;
      func_r <= 4'h0;
      afld_r <= 4'h0;
      idx_r <= 1'b0;
    end else if (wr_go & idle) begin
      if (wa == `WSU_UFLD) begin
        ufld_r <= m_u[17:0];
      end
      if (wa == `WSU_XVAL) begin
        xval_r <= m_x[17:0];
      end
      if (wa == `WSU_CTRL) begin
        func_r <= sfunc;
        afld_r <= m_ctrl[`WSU_C_AHI:`WSU_C_ALO];
        idx_r <= m_ctrl[`WSU_C_IDX];
      end
    end
  end

  // operand views
  wire [35:0] a0 = opnd[0];
  wire [35:0] a1 = opnd[1];
  wire [35:0] m0 = opnd[2];
  wire [35:0] m1 = opnd[3];
  wire [71:0] dv = {a0, a1};
  wire [71:0] dm = {m0, m1};
  wire [6:0] n = nq_r;
  // single circular count folded into 0..35
  wire [6:0] nw = (n >= 7'd36) ? n - 7'd36 : n;
  wire [6:0] nc = (nw == 7'd36) ? 7'd0 : nw;
  // double circular: 72 is a full turn
  wire [6:0] dn = (n == 7'd72) ? 7'd0 : n;
  wire [71:0] s2 = {a0, a0};
  wire [143:0] d2 = {dv, dv};
  wire [71:0] s_rr = s2 >> nc;
  wire [71:0] s_rl = s2 << nc;
  wire [143:0] d_rr = d2 >> dn;
  wire [143:0] d_rl = d2 << dn;
  // plain shifts zero out fully once n reaches the width
  wire [35:0] s_lr = a0 >> n;
  wire [35:0] s_ll = a0 << n;
  wire [71:0] d_lr = dv >> n;
  wire [71:0] d_ll = dv << n;
  // sign copies sit above the value, deep enough for every count up to 72
  wire [143:0] s_sr = {{108{a0[35]}}, a0} >> n;
  wire [143:0] d_sr = {{72{dv[71]}}, dv} >> n;

  // scaling count: the last hit is the smallest rotation
  reg [6:0] lc; // single count
  reg [6:0] dc; // double count
  integer j;
  always @* begin
    lc = 7'd35;
    dc = 7'd71;
    for (j = 0; j < 35; j = j + 1) begin
      if (m0[j+1] != m0[j]) begin
        lc = 7'd34 - j[6:0];
      end
    end
    for (j = 0; j < 71; j = j + 1) begin
      if (dm[j+1] != dm[j]) begin
        dc = 7'd70 - j[6:0];
      end
    end
  end
  // a uniform word is unchanged by any rotation
  wire [71:0] l_rot = {m0, m0} << lc;
  wire [143:0] dl_rot = {dm, dm} << dc;

  // result select; counts above 72 give whatever falls out
  reg [35:0] r0; // next first result
  reg [35:0] r1; // next second result
  reg [6:0] rc; // next count
  reg [5:0] cy; // run length of the code being started
  always @* begin
    r0 = a0;
    r1 = a1;
    rc = 7'd0;
    case (fq_r)
      `WSU_F_SRR: r0 = s_rr[35:0];
      `WSU_F_DRR: {r0, r1} = d_rr[71:0];
      `WSU_F_SLR: r0 = s_lr;
      `WSU_F_DLR: {r0, r1} = d_lr;
      `WSU_F_SSR: r0 = s_sr[35:0];
      `WSU_F_DSR: {r0, r1} = d_sr[71:0];
      `WSU_F_LSC: begin
        r0 = l_rot[71:36];
        rc = lc;
      end
      `WSU_F_DLSC: begin
        {r0, r1} = dl_rot[143:72];
        rc = dc;
      end
      `WSU_F_SRL: r0 = s_rl[71:36];
      `WSU_F_DRL: {r0, r1} = d_rl[143:72];
      `WSU_F_SLL: r0 = s_ll;
      `WSU_F_DLL: {r0, r1} = d_ll;
      default: r0 = a0;
    endcase
    // run length chosen from the code at the start write
    case (sfunc)
      `WSU_F_SRR, `WSU_F_SLR, `WSU_F_SSR: cy = CY_SGL[5:0];
      `WSU_F_SRL, `WSU_F_SLL: cy = CY_SGL[5:0];
      `WSU_F_LSC: cy = CY_LSC[5:0];
      `WSU_F_DLSC: cy = CY_DLSC[5:0];
      default: cy = CY_DBL[5:0];
    endcase
  end
  // pair partner addresses; a=17 octal lands on 034 octal
  wire [6:0] acc = `WSU_ACC_BASE + {3'h0, aq_r};
  wire [6:0] acc1 = acc + 7'h01;
  wire [6:0] acc2 = acc + 7'h02;
  wire dbl = fq_r[0]; // odd codes are the pair forms, scaling included

  // sequencer: start, timed run, store and flag done
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      tmr_r <= 6'h0;
      fq_r <= 4'h0;
      aq_r <= 4'h0;
      nq_r <= 7'h0;
      effu_r <= 18'h0;
      res0_r <= 36'h0;
      res1_r <= 36'h0;
      rcnt_r <= 7'h0;
      done_r <= 1'b0;
      badf_r <= 1'b0;
      rng_r <= 1'b0;
      dst0_r <= 7'h0;
      dst1_r <= 7'h0;
      dstc_r <= 7'h0;
    end else begin
      // software clear of done; a completion in the same cycle wins
      if (wr_stat & wd_r[`WSU_S_DONE] & ws_r[0]) begin
        done_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            badf_r <= ~f_ok;
            // the count is only the low address bits
            rng_r <= (effu[17:7] != 11'h0);
            effu_r <= effu;
            if (f_ok) begin
              done_r <= 1'b0;
              fq_r <= sfunc;
              aq_r <= m_ctrl[`WSU_C_AHI:`WSU_C_ALO];
              nq_r <= effu[6:0];
              tmr_r <= cy - 6'h01;
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (tmr_r == 6'h0) begin
            // results go back to the same register or pair
            res0_r <= r0;
            res1_r <= r1;
            rcnt_r <= rc;
            dst0_r <= acc;
            dst1_r <= dbl ? acc1 : 7'h0;
            // count lands just past the scaled value
            if (fq_r == `WSU_F_LSC) begin
              dstc_r <= acc1;
            end else if (fq_r == `WSU_F_DLSC) begin
              dstc_r <= acc2;
            end else begin
              dstc_r <= 7'h0;
            end
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            tmr_r <= tmr_r - 6'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // read decode
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire [7:0] ro = ra - `WSU_OPW;
  wire [7:0] rr = ra - `WSU_RES;
  wire [35:0] ow = opnd[ro[4:3]];
  wire [35:0] rw = rr[3] ? res1_r : res0_r;
  reg [31:0] rd; // read word
  always @* begin
    rd = 32'h0;
    if (ra == `WSU_CTRL) begin
      rd = {23'h0, idx_r, afld_r, func_r};
    end else if (ra == `WSU_UFLD) begin
      rd = {14'h0, ufld_r};
    end else if (ra == `WSU_XVAL) begin
      rd = {14'h0, xval_r};
    end else if ((ra >= `WSU_OPW) & (ra < `WSU_OPEND)) begin
      // low word at the even slot, top four bits above it
      rd = ro[2] ? {28'h0, ow[35:32]} : ow[31:0];
    end else if ((ra >= `WSU_RES) & (ra < `WSU_CNT)) begin
      rd = rr[2] ? {28'h0, rw[35:32]} : rw[31:0];
    end else if (ra == `WSU_CNT) begin
      rd = {25'h0, rcnt_r};
    end else if (ra == `WSU_STAT) begin
      rd = {1'b0, dstc_r, 1'b0, dst1_r, 1'b0, dst0_r,
            4'h0, rng_r, badf_r, done_r, state_r[1]};
    end else if (ra == `WSU_EFFU) begin
      rd = {14'h0, effu_r};
    end
  end

  // read channel: one read at a time, answer the cycle after
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `WSU_OKAY;
    end else begin
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_rdata <= rd;
        s_axi_rresp <= (ra > `WSU_EFFU) ? `WSU_SLVERR : `WSU_OKAY;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- tb/wsu_shift_unit_props.sv
// protocol checks on the register port of the shift unit
`timescale 1ns/1ps
module wsu_shift_unit_props (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // address and data taken at one edge
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // the answer comes one idle cycle later
  sequence wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_take |=> wr_answer)
    else $error("write answer late or early");
  wr_block_a: assert property (wr_take |=>
    (!s_axi_awready && !s_axi_wready) [*2])
    else $error("write channels ready again before answer");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write answer not released");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after take");
  r_release_a: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  rd_error_a: assert property ((rd_take and (s_axi_araddr > 8'h44)) |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  rd_okay_a: assert property ((rd_take and (s_axi_araddr <= 8'h44)) |=>
    s_axi_rresp == 2'h0)
    else $error("mapped read refused");
  wr_error_a: assert property ((wr_take and (s_axi_awaddr > 8'h44)) |->
    ##2 s_axi_bresp == 2'h2)
    else $error("unmapped write not refused");
endmodule
bind wsu_shift_unit wsu_shift_unit_props i_props (.*);

//--- tb/wsu_bus_master.sv
// register-bus master standing in for instruction control
`timescale 1ns/1ps
module wsu_bus_master (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
  end
  // one write; address and data offered together, all strobes set
  task automatic write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // one read; rready held until the answer is sampled
  task automatic read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

//--- tb/wsu_shift_unit_tb.sv
// self-checking bench: shifts, scaling and addressing over the bus
`timescale 1ns/1ps
`include "wsu_defs.vh"
module wsu_shift_unit_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int mismatches = 0;
  int n_compared = 0;
  // counts at the edges of the defined range
  int cnts [5] = '{0, 6, 36, 37, 72};
  // operands: mixed, plus zero, minus zero, unscaled
  logic [71:0] ops [4] = '{72'hFAC68829C3C5A69E1B, 72'h0, {72{1'b1}},
    72'h00000F00A5A5A5A5A5};
  wsu_shift_unit i_wsu_shift_unit (.*);
  wsu_bus_master i_wsu_bus_master (.*);
  // 50 ns clock
  always #25 aclk = ~aclk;
  task automatic chk(input string what, input logic [71:0] seen,
      input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_wsu_bus_master.write(a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    i_wsu_bus_master.read(a, d, r);
  endtask
  // a 36-bit word spans two bus words
  task automatic put36(input logic [7:0] a, input logic [35:0] v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {28'h0, v[35:32]});
  endtask
  task automatic get36(input logic [7:0] a, output logic [35:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(a, lo);
    rd(a + 8'h04, hi);
    v = {hi[3:0], lo};
  endtask
  // start, see busy at once, then poll for done
  task automatic go(input logic [8:0] ctl, output logic [31:0] st);
    wr(`WSU_CTRL, {1'b1, 22'h0, ctl});
    rd(`WSU_STAT, st);
    chk("busy", st[0], 1'b1);
    while (st[1] !== 1'b1) rd(`WSU_STAT, st);
  endtask
  // expected {A, A+1} after one operation, count in c
  function automatic logic [71:0] model(input logic [3:0] f, input int n,
      input logic [71:0] v, output int c);
    logic [143:0] tr;
    logic [143:0] tl;
    logic [71:0] qr;
    logic [71:0] ql;
    logic [71:0] r;
    logic [35:0] s;
    s = v[71:36];
    r = v;
    c = 0; // the count register holds only a scaling count
    qr = {s, s} >> (n % 36);
    ql = {s, s} << (n % 36);
    tr = {v, v} >> (n % 72);
    tl = {v, v} << (n % 72);
    case (f)
      4'h0: r[71:36] = qr[35:0];
      4'h1: r = tr[71:0];
      4'h2: r[71:36] = s >> n;
      4'h3: r = v >> n;
      4'h4: r[71:36] = $signed(s) >>> n;
      4'h5: r = $signed(v) >>> n;
      4'h8: r[71:36] = ql[71:36];
      4'h9: r = tl[143:72];
      4'hA: r[71:36] = s << n;
      4'hB: r = v << n;
      default: begin
        // scaling: walk down so the smallest rotation wins
        c = f[0] ? 71 : 35;
        for (int k = c - 1; k >= 0; k--) begin
          tl = {v, v} << k;
          ql = {s, s} << k;
          if (f[0] && tl[143] != tl[142]) begin
            r = tl[143:72];
            c = k;
          end
          if (!f[0] && ql[71] != ql[70]) begin
            r[71:36] = ql[71:36];
            c = k;
          end
        end
      end
    endcase
    return r;
  endfunction
  // load operands and count, run one function, compare
  task automatic one(input logic [3:0] f, input int n,
      input logic [71:0] v);
    logic [71:0] e;
    logic [35:0] r0;
    logic [35:0] r1;
    logic [31:0] st;
    int c;
    logic [6:0] dcn;
    e = model(f, n, v, c);
    put36(8'h0C, v[71:36]);
    put36(8'h14, v[35:0]);
    put36(8'h1C, v[71:36]);
    put36(8'h24, v[35:0]);
    wr(`WSU_UFLD, n);
    go({5'h0, f}, st);
    dcn = f == 4'h7 ? 7'h0E : f == 4'h6 ? 7'h0D : 7'h00;
    chk("dest0", st[14:8], 7'h0C);
    chk("dest1", st[22:16], f[0] ? 7'h0D : 7'h00);
    chk("dest count", st[30:24], dcn);
    get36(`WSU_RES, r0);
    get36(8'h34, r1);
    rd(`WSU_CNT, st);
    chk("result0", r0, e[71:36]);
    if (f != 4'h6) chk("result1", r1, e[35:0]);
    chk("count", st[6:0], c[6:0]);
    rd(`WSU_EFFU, st);
    chk("shift count", st, n);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`WSU_STAT, d);
    chk("status reset", d, 32'h0);
    i_wsu_bus_master.read(8'h48, d, r);
    chk("unmapped read", {d, r}, {32'h0, `WSU_SLVERR});
    i_wsu_bus_master.write(8'h48, 32'hFFFFFFFF, r);
    chk("unmapped write", r, `WSU_SLVERR);
    foreach (ops[i])
      for (int f = 0; f < 12; f++)
        foreach (cnts[k]) one(f[3:0], cnts[k], ops[i]);
    // minus one plus seven with end-around carry gives six
    wr(`WSU_UFLD, 32'h3FFFE);
    wr(`WSU_XVAL, 32'h7);
    go({1'b1, 4'h0, 4'h0}, d);
    chk("range flag", d[3], 1'b0);
    rd(`WSU_EFFU, d);
    chk("eff u", d, 32'h6);
    wr(`WSU_UFLD, 32'h86);
    go({1'b0, 4'hF, 4'h1}, d);
    chk("pair dest", {d[3], d[22:16], d[14:8]}, {1'b1, 7'h1C, 7'h1B});
    // an unknown code is flagged and not run; done stays until cleared
    wr(`WSU_CTRL, 32'h8000000C);
    rd(`WSU_STAT, d);
    chk("bad code", d[2:0], 3'b110);
    wr(`WSU_STAT, 32'h2);
    rd(`WSU_STAT, d);
    chk("done clear", d[2:0], 3'b100);
    test_done;
  end
  // hang guard, about four times the expected run
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    test_done;
  end
endmodule
